// *** hw/hdsm_cfg.svh ***
// timing counts and widths for the half-duplex serial master
`ifndef HDSM_CFG_SVH
`define HDSM_CFG_SVH
`define HDSM_CLK_MHZ        125
`define HDSM_HALF_DIV_RESET 8'h04
`define HDSM_BITS_PER_BYTE  4'h8
`define HDSM_BIT_MSB        3'h7
`define HDSM_FIFO_WIDTH     8
`define HDSM_FIFO_DEPTH     32
`define HDSM_FIFO_AW        5
`endif

// *** hw/hdsm_pkg.sv ***
// types for the half-duplex serial master
package hdsm_pkg;
  typedef enum logic [1:0] {
    HDSM_IDLE,
    HDSM_HIGH,
    HDSM_LOW
  } hdsm_state_t;
  typedef struct packed {
    logic       write;
    logic [7:0] data;
  } hdsm_cmd_t;
endpackage

// *** hw/hdsm_fifo.sv ***
// parameterised fifo with valid and ready on both sides
`timescale 1ns/1ns
module hdsm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign count_nxt   = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem[rd_ptr_r];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r    <= count_nxt;
      o_in_ready <= (count_nxt != DEPTH[AW:0]);
    end
  end

  a_fifo_no_overfill: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    count_r <= DEPTH[AW:0]) else $error("fifo count above depth");
endmodule // hdsm_fifo

// *** hw/hdsm_master.sv ***
// half-duplex three-wire serial master with command fifo
`timescale 1ns/1ns
`include "hdsm_cfg.svh"
module hdsm_master (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_init,
  input  wire logic [7:0]        i_half_div,
  input  wire logic              i_sel_en,
  input  wire logic              i_cmd_valid,
  output logic                   o_cmd_ready,
  input  wire hdsm_pkg::hdsm_cmd_t i_cmd,
  output logic                   o_rd_valid,
  output logic [7:0]             o_rd_data,
  output logic                   o_wr_done,
  output logic                   o_busy,
  output logic                   o_ready_cfg,
  output logic                   o_sck,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  input  wire logic              i_sda_in,
  output logic                   o_sda_pullup,
  output logic                   o_sel_n
);
  // ==========================================================================
  // input synchroniser
  logic sda_meta_r;
  logic sda_sync_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      sda_meta_r <= i_sda_in;
      sda_sync_r <= sda_meta_r;
    end
  end

  // ==========================================================================
  // command fifo
  logic                fifo_valid;
  logic                fifo_ready;
  logic [8:0]          fifo_data;
  hdsm_pkg::hdsm_cmd_t cur_cmd;
  assign cur_cmd = hdsm_pkg::hdsm_cmd_t'(fifo_data);

  hdsm_fifo #(
    .WIDTH(`HDSM_FIFO_WIDTH + 1),
    .DEPTH(`HDSM_FIFO_DEPTH),
    .AW   (`HDSM_FIFO_AW)
  ) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_in_valid (i_cmd_valid),
    .o_in_ready (o_cmd_ready),
    .i_in_data  (i_cmd),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready),
    .o_out_data (fifo_data)
  );

  // ==========================================================================
  // init: latch configuration
  logic       cfg_done_r;
  logic [7:0] half_div_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_done_r <= 1'b0;
      half_div_r <= `HDSM_HALF_DIV_RESET;
    end else if (i_init && !o_busy) begin
      cfg_done_r <= 1'b1;
      half_div_r <= (i_half_div == 8'h00) ? 8'h01 : i_half_div;
    end
  end

  // ==========================================================================
  // half-period divider enable
  logic [7:0]            div_cnt_r;
  logic                  tick;
  hdsm_pkg::hdsm_state_t state_r;
  assign tick = (state_r != hdsm_pkg::HDSM_IDLE) && (div_cnt_r == half_div_r - 8'h01);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_r <= 8'h00;
    end else if (state_r == hdsm_pkg::HDSM_IDLE || tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // ==========================================================================
  // bit sequencer
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic       is_wr_r;
  logic       start;
  logic       last_bit;
  assign start      = (state_r == hdsm_pkg::HDSM_IDLE) && fifo_valid && cfg_done_r;
  assign fifo_ready = start;
  assign last_bit   = (bit_cnt_r == `HDSM_BITS_PER_BYTE - 4'h1);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r   <= hdsm_pkg::HDSM_IDLE;
      bit_cnt_r <= 4'h0;
      is_wr_r   <= 1'b0;
    end else begin
      unique case (state_r)
        hdsm_pkg::HDSM_IDLE: begin
          if (start) begin
            state_r   <= hdsm_pkg::HDSM_HIGH;
            bit_cnt_r <= 4'h0;
            is_wr_r   <= cur_cmd.write;
          end
        end
        hdsm_pkg::HDSM_HIGH: begin
          if (tick) begin
            state_r <= hdsm_pkg::HDSM_LOW;
          end
        end
        hdsm_pkg::HDSM_LOW: begin
          if (tick) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            state_r   <= last_bit ? hdsm_pkg::HDSM_IDLE : hdsm_pkg::HDSM_HIGH;
          end
        end
      endcase
    end
  end

  // shift register, msb first out
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= 8'h00;
    end else if (start) begin
      shift_r <= cur_cmd.data;
    end else if (state_r == hdsm_pkg::HDSM_LOW && tick) begin
      shift_r <= {shift_r[6:0], 1'b1};
    end
  end

  // ==========================================================================
  // pins
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sck     <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b1;
    end else begin
      o_sck     <= (state_r == hdsm_pkg::HDSM_HIGH);
      // drive only in high half, release in low half
      o_sda_oe  <= (state_r == hdsm_pkg::HDSM_HIGH) && is_wr_r;
      o_sda_out <= shift_r[`HDSM_BIT_MSB];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda_pullup <= 1'b0;
      o_sel_n      <= 1'b1;
      o_busy       <= 1'b0;
      o_ready_cfg  <= 1'b0;
    end else begin
      o_sda_pullup <= 1'b1;
      o_sel_n      <= !(i_sel_en && state_r != hdsm_pkg::HDSM_IDLE);
      o_busy       <= (state_r != hdsm_pkg::HDSM_IDLE) || start;
      o_ready_cfg  <= cfg_done_r;
    end
  end

  // ==========================================================================
  // receive capture, delayed by the synchroniser latency
  logic       done;
  logic       rx_last;
  logic [1:0] cap_pipe_r;
  logic [1:0] done_pipe_r;
  logic [1:0] wr_pipe_r;
  logic [7:0] rx_r;
  assign done    = (state_r == hdsm_pkg::HDSM_LOW) && tick && last_bit;
  assign rx_last = done_pipe_r[1];

  // end of low half, seen two cycles later through the synchroniser
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_pipe_r  <= 2'b00;
      done_pipe_r <= 2'b00;
      wr_pipe_r   <= 2'b00;
    end else begin
      cap_pipe_r  <= {cap_pipe_r[0], (state_r == hdsm_pkg::HDSM_LOW) && tick};
      done_pipe_r <= {done_pipe_r[0], done};
      wr_pipe_r   <= {wr_pipe_r[0], is_wr_r};
    end
  end

  // incoming bits, msb first
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_r <= 8'h00;
    end else if (cap_pipe_r[1]) begin
      rx_r <= {rx_r[6:0], sda_sync_r};
    end
  end

  // completion strobes
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_wr_done  <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_rd_valid <= rx_last && !wr_pipe_r[1];
      o_wr_done  <= rx_last && wr_pipe_r[1];
      if (rx_last && !wr_pipe_r[1]) begin
        o_rd_data <= {rx_r[6:0], sda_sync_r};
      end
    end
  end

  // ==========================================================================
  // assertions
  // helper counters: clock rises per byte, length of each high half
  logic       sck_d_r;
  logic [3:0] rise_cnt_r;
  logic [7:0] hi_len_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_d_r    <= 1'b0;
      rise_cnt_r <= 4'h0;
    end else begin
      sck_d_r <= o_sck;
      if (start) begin
        rise_cnt_r <= 4'h0;
      end else if (o_sck && !sck_d_r) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_len_r <= 8'h00;
    end else if (o_sck) begin
      hi_len_r <= hi_len_r + 8'h01;
    end else begin
      hi_len_r <= 8'h00;
    end
  end

  a_oe_only_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_sda_oe |-> o_sck) else $error("data driven while clock low");
  a_sck_idle_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(state_r == hdsm_pkg::HDSM_IDLE) |-> !o_sck) else $error("clock not low idle");
  a_first_half_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start |=> ##1 o_sck) else $error("period not starting high");
  a_oe_write_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == hdsm_pkg::HDSM_HIGH && is_wr_r) |=> o_sda_oe) else $error("no drive");
  a_data_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_sda_oe && $past(o_sda_oe)) |-> $stable(o_sda_out)) else $error("data moved");
  a_eight_bits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    done |-> bit_cnt_r == 4'h7) else $error("byte not eight bits");
  a_pullup_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_sda_pullup) else $error("pullup off");
  a_msb_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    start |=> shift_r[7] == $past(cur_cmd.data[7])) else $error("msb not first");
  a_sel_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_sel_en |=> o_sel_n) else $error("select driven");
  a_no_start_uncfg: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cfg_done_r |-> !start) else $error("transfer before init");

  c_write_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_wr_done);
  c_read_done: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_rd_valid);
  a_eight_rises: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    done |-> rise_cnt_r == `HDSM_BITS_PER_BYTE) else $error("rise count not eight");
  a_half_len: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (sck_d_r && !o_sck) |-> hi_len_r == half_div_r) else $error("high half wrong length");
  a_sck_in_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_sck |-> o_busy) else $error("clock outside transfer");
  a_strobe_excl: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !(o_rd_valid && o_wr_done)) else $error("both strobes high");
  a_init_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_init && o_busy) |=> $stable(half_div_r)) else $error("divider changed while busy");
  a_rd_data_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_rd_valid |-> $stable(o_rd_data)) else $error("read data moved");

  c_fifo_full: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) !o_cmd_ready);
  c_init_busy: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) i_init && o_busy);
endmodule // hdsm_master

// *** test/hdsm_slave_model.sv ***
// behavioural serial slave on the shared data line
`timescale 1ns/1ns
module hdsm_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_sda,
  input  wire logic [31:0] i_lag_ns,
  output logic            o_oe,
  output logic [0:0]      o_val,
  output logic [7:0]      o_rx_byte,
  output logic [7:0]      o_tx_byte
);
  logic [2:0] bit_idx;
  logic [2:0] rx_idx;
  logic [7:0] rx_sh;
  logic [7:0] byte_num;
  logic       armed;
  initial begin
    o_oe = 1'b0;
    o_val = 1'b1;
    o_rx_byte = 8'h00;
    o_tx_byte = 8'h96;
    bit_idx = 3'h0;
    rx_idx = 3'h0;
    rx_sh = 8'h00;
    byte_num = 8'h00;
    armed = 1'b0;
  end
  // ==========
  // high half: let go, then take the master bit; whole byte published
  always @(posedge i_sck) begin
    o_oe = 1'b0;
    armed = 1'b1;
    #4;
    rx_sh = {rx_sh[6:0], i_sda};
    rx_idx = rx_idx + 3'h1;
    if (rx_idx == 3'h0) begin
      o_rx_byte = rx_sh;
    end
  end
  // ==========
  // low half: answer after the lag, msb first; reset fall ignored
  always @(negedge i_sck) begin
    if (armed === 1'b1) begin
      #(i_lag_ns);
      if (!i_sck) begin
        o_oe = 1'b1;
        o_val = o_tx_byte[3'h7 - bit_idx];
      end
      bit_idx = bit_idx + 3'h1;
      if (bit_idx == 3'h0) begin
        byte_num = byte_num + 8'h01;
        o_tx_byte = byte_num * 8'h1D + 8'h96;
      end
    end
  end
endmodule // hdsm_slave_model

// *** test/tb_top.sv ***
// self-checking bench for the half-duplex serial master
`timescale 1ns/1ns
module tb_top;
  logic                i_clk_sys, i_rst_n, i_init, i_sel_en, i_cmd_valid;
  logic [7:0]          i_half_div, o_rd_data, slv_rx, k, tx_exp, hd_exp;
  hdsm_pkg::hdsm_cmd_t i_cmd, c_exp;
  hdsm_pkg::hdsm_cmd_t exp_q[$];
  logic                o_cmd_ready, o_rd_valid, o_wr_done, o_busy, o_ready_cfg, o_sck;
  logic                o_sda_out, o_sda_oe, o_sda_pullup, o_sel_n, slv_oe, slv_val;
  logic [31:0]         seed;
  int                  fails, tests_run, hi_cnt, rises, lag_ns, w;
  wire                 sda = o_sda_oe ? o_sda_out : slv_oe ? slv_val : o_sda_pullup;
  hdsm_master hdsm_master_inst (.i_clk_sys, .i_rst_n, .i_init, .i_half_div, .i_sel_en,
    .i_cmd_valid, .o_cmd_ready, .i_cmd, .o_rd_valid, .o_rd_data, .o_wr_done, .o_busy,
    .o_ready_cfg, .o_sck, .o_sda_out, .o_sda_oe, .i_sda_in(sda), .o_sda_pullup, .o_sel_n);
  hdsm_slave_model hdsm_slave_model_inst (.i_sck(o_sck), .i_sda(sda), .i_lag_ns(lag_ns),
    .o_oe(slv_oe), .o_val(slv_val), .o_rx_byte(slv_rx), .o_tx_byte());
  // ==========
  // shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out();
    $display("counts run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task push_rand();
    seed = lfsr(seed);
    i_cmd_valid <= 1'b1;
    i_cmd <= {seed[0], seed[8:1]};
    do @(posedge i_clk_sys); while (o_cmd_ready !== 1'b1);
    exp_q.push_back(i_cmd);
  endtask
  task do_init(input logic [7:0] h);
    i_init <= 1'b1;
    i_half_div <= h;
    @(posedge i_clk_sys);
    i_init <= 1'b0;
  endtask
  task drain(input string name);
    w = 0;
    while (exp_q.size() != 0 && w < 9000) begin
      @(posedge i_clk_sys);
      w++;
    end
    check(exp_q.size(), 0);
    $display("test %s done", name);
  endtask
  // ==========
  // wire and result monitor
  always @(posedge i_clk_sys) begin
    if (i_rst_n) begin
      check(o_sda_oe & slv_oe, 1'b0);
      if (o_busy === 1'b0) check(o_sck, 1'b0);
      if ((o_rd_valid === 1'b1 || o_wr_done === 1'b1) && exp_q.size() > 0) begin
        c_exp = exp_q.pop_front();
        tx_exp = k * 8'h1D + 8'h96;
        check(o_wr_done, c_exp.write);
        check(rises, 8);
        check(slv_rx, c_exp.write ? c_exp.data : 8'hFF);
        if (!c_exp.write) check(o_rd_data, tx_exp);
        k = k + 8'h01;
        rises = 0;
      end
      if (o_sck === 1'b1) begin
        if (hi_cnt == 0) rises = rises + 1;
        hi_cnt = hi_cnt + 1;
        check(o_sel_n, !i_sel_en);
        if (exp_q.size() > 0) check(o_sda_oe, exp_q[0].write);
      end else begin
        check(o_sda_oe, 1'b0);
        if (hi_cnt != 0) check(hi_cnt, hd_exp);
        hi_cnt = 0;
      end
    end
  end
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    close_out();
  end
  // ==========
  // main sequence
  initial begin
    {i_rst_n, i_init, i_sel_en, i_cmd_valid} = 4'h0;
    i_half_div = 8'h04;
    i_cmd = '0;
    seed = 32'h0001_2CCB;
    {fails, tests_run, hi_cnt, rises} = '0;
    k = 8'h00;
    hd_exp = 8'h03;
    lag_ns = 1;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    check(o_sda_pullup, 1'b1);
    check(o_ready_cfg, 1'b0);
    for (int n = 0; n < 32; n++) push_rand();
    i_cmd_valid <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    check(o_cmd_ready, 1'b0);
    check(o_sck, 1'b0);
    do_init(8'h03);
    drain("fill_drain");
    check(o_ready_cfg, 1'b1);
    i_sel_en <= 1'b1;
    lag_ns = 12;
    hd_exp = 8'h04;
    do_init(8'h04);
    for (int n = 0; n < 8; n++) push_rand();
    i_cmd_valid <= 1'b0;
    w = 0;
    while (o_sck !== 1'b1 && w < 200) begin
      @(posedge i_clk_sys);
      w++;
    end
    do_init(8'h09);
    drain("slow_select_busy_init");
    close_out();
  end
endmodule // tb_top
